// ### common/llsi_pkg.sv
// constants for the lane 7 link status and link interrupt enable block
package llsi_pkg;

  // register offsets on the configuration port
  localparam logic [11:0] LINK_PAGE_ADDR   = 12'h0300;
  localparam logic [11:0] CFG_FIRST_ADDR   = 12'h0450;
  localparam logic [11:0] CFG_LAST_ADDR    = 12'h045D;
  localparam logic [11:0] LANE7_STAT_ADDR  = 12'h04B7;
  localparam logic [11:0] IRQ_EN_A_ADDR    = 12'h04B8;
  localparam logic [11:0] IRQ_EN_B_ADDR    = 12'h04B9;
  localparam logic [11:0] PIN_SEL_ADDR     = 12'h04BC;
  localparam logic [11:0] ERR_THRESH_ADDR  = 12'h04C0;

  // number of programmed alignment-sequence bytes checked on lane 0
  localparam int          CFG_BYTES        = 14;

  // lane 7 status field positions
  localparam int          BDE_BIT          = 7;
  localparam int          NIT_BIT          = 6;
  localparam int          UEK_BIT          = 5;
  localparam int          ILD_BIT          = 4;
  localparam int          ILS_BIT          = 3;
  localparam int          CKS_BIT          = 2;
  localparam int          FS_BIT           = 1;
  localparam int          CGS_BIT          = 0;

  // second enable register: configuration mismatch enable
  localparam int          MISMATCH_EN_BIT  = 0;
  // routing select field
  localparam int          PIN_SEL_BIT      = 0;

  // reset values
  localparam logic [7:0]  IRQ_EN_A_RST     = 8'h00;
  localparam logic        IRQ_EN_B_RST     = 1'b0;
  localparam logic        PIN_SEL_RST      = 1'b0;
  localparam logic [7:0]  ERR_THRESH_RST   = 8'hFF;
  localparam logic [7:0]  READ_ZERO        = 8'h00;

endpackage : llsi_pkg

// ### logic/llsi_cfg_mem.sv
// small memory holding the programmed alignment-sequence bytes per link
`timescale 1ns/1ps
`default_nettype none

module llsi_cfg_mem #(
  parameter int AW = 5,                       // address width
  parameter int DW = 8                        // data width
) (
  input  wire logic          core_clk_i,      // register clock
  input  wire logic          sys_rst_i,       // async reset, active high
  input  wire logic          wr_en_i,         // write strobe
  input  wire logic [AW-1:0] wr_addr_i,       // write address
  input  wire logic [DW-1:0] wr_data_i,       // write data
  input  wire logic          rd_en_i,         // read strobe
  input  wire logic [AW-1:0] rd_addr_i,       // read address
  output logic      [DW-1:0] rd_data_o        // registered read data
);

  logic [DW-1:0] mem_q [2**AW];

  // array holds no reset so it maps onto plain storage
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // read data leaves through a register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule : llsi_cfg_mem

`default_nettype wire

// ### logic/llsi_top.sv
// lane 7 link status readback and per-link interrupt enables
// Operation
// - bit 3 of lane 7 status reads initial lane sync, resets 0
// - bit 2 reads whether the received lane 7 checksum matched, resets 0
// - bit 1 of lane 7 status reads frame sync state
// - bit 0 of lane 7 status reads code-group sync, resets 0
// - all status and enables are banked per link, chosen by page register
// - first enable register holds eight read-write enables, reset 0
// - checksum source compares sent checksum with checksum computed by receiver
// - checksum compare ignores the software programmed checksum byte
// - second enable bit 0 enables lane 0 configuration mismatch interrupt
// - select bit routes combined interrupt to first or second pin
// - error flag reads 1 once count reaches threshold, else 0
`timescale 1ns/1ps
`default_nettype none
module llsi_top #(
  parameter int NUM_LINKS = 2,                // number of link banks
  parameter int LW = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1
) (
  input  wire logic                   core_clk_i,      // register clock
  input  wire logic                   sys_rst_i,       // async reset
  input  wire logic [11:0]            reg_addr_i,      // register address
  input  wire logic                   reg_wr_i,        // register write
  input  wire logic [7:0]             reg_wdata_i,     // write data
  output logic      [7:0]             reg_rdata_o,     // read data
  input  wire logic [NUM_LINKS-1:0]   lane7_ils_i,     // initial lane sync
  input  wire logic [NUM_LINKS-1:0]   lane7_fs_i,      // frame sync
  input  wire logic [NUM_LINKS-1:0]   lane7_cgs_i,     // code-group sync
  input  wire logic [NUM_LINKS-1:0]   lane7_ild_i,     // deskew achieved
  input  wire logic [NUM_LINKS*8-1:0] lane7_bde_cnt_i, // disparity count
  input  wire logic [NUM_LINKS*8-1:0] lane7_nit_cnt_i, // not-in-table count
  input  wire logic [NUM_LINKS*8-1:0] lane7_uek_cnt_i, // control char count
  input  wire logic [NUM_LINKS-1:0]   lane7_cks_vld_i, // checksum pair valid
  input  wire logic [NUM_LINKS*8-1:0] lane7_cks_rx_i,  // checksum sent
  input  wire logic [NUM_LINKS*8-1:0] lane7_cks_calc_i,// checksum computed
  input  wire logic                   ilas_vld_i,      // lane 0 byte valid
  input  wire logic [LW-1:0]          ilas_link_i,     // link of the byte
  input  wire logic [3:0]             ilas_idx_i,      // byte index
  input  wire logic [7:0]             ilas_byte_i,     // received byte
  output logic                        irq_out_first_o, // first irq pin
  output logic                        irq_out_second_o // second irq pin
);
  localparam int MAW = LW + 4;
  logic [LW-1:0]  page_q;
  logic [7:0]     en_a_q     [NUM_LINKS];
  logic           en_b_q     [NUM_LINKS];
  logic           pin_sel_q;
  logic [7:0]     thresh_q;
  logic [2:0]     err_q      [NUM_LINKS];
  logic           cks_ok_q   [NUM_LINKS];
  logic           mismatch_q [NUM_LINKS];
  logic           cmp_vld_q;
  logic           cmp_first_q;
  logic [LW-1:0]  cmp_link_q;
  logic [7:0]     cmp_byte_q;
  logic [7:0]     mem_rd_data;
  logic           cfg_wr;
  logic           ilas_rd;
  logic           irq_any;
  logic [7:0]     stat_sel;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  assign cfg_wr = reg_wr_i && (reg_addr_i >= llsi_pkg::CFG_FIRST_ADDR)
                  && (reg_addr_i <= llsi_pkg::CFG_LAST_ADDR);
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_q <= '0;
    end else if (reg_wr_i && reg_addr_i == llsi_pkg::LINK_PAGE_ADDR) begin
      page_q <= reg_wdata_i[LW-1:0];
    end
  end
  // banked enables, only the selected page takes a write
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_a_q <= '{default: llsi_pkg::IRQ_EN_A_RST};
      en_b_q <= '{default: llsi_pkg::IRQ_EN_B_RST};
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (reg_wr_i && page_q == LW'(l)) begin
          if (reg_addr_i == llsi_pkg::IRQ_EN_A_ADDR) begin
            en_a_q[l] <= reg_wdata_i;
          end
          if (reg_addr_i == llsi_pkg::IRQ_EN_B_ADDR) begin
            en_b_q[l] <= reg_wdata_i[llsi_pkg::MISMATCH_EN_BIT];
          end
        end
      end
    end
  end
  // routing select and error threshold are shared by all links
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_sel_q <= llsi_pkg::PIN_SEL_RST;
      thresh_q  <= llsi_pkg::ERR_THRESH_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == llsi_pkg::PIN_SEL_ADDR) begin
        pin_sel_q <= reg_wdata_i[llsi_pkg::PIN_SEL_BIT];
      end
      if (reg_addr_i == llsi_pkg::ERR_THRESH_ADDR) begin
        thresh_q <= reg_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link status
  // error flags against the threshold, registered for clean timing
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_q <= '{default: '0};
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        err_q[l] <= {lane7_bde_cnt_i[l*8 +: 8] >= thresh_q,
                     lane7_nit_cnt_i[l*8 +: 8] >= thresh_q,
                     lane7_uek_cnt_i[l*8 +: 8] >= thresh_q};
      end
    end
  end
  // sent versus computed checksum; the programmed byte never enters
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cks_ok_q <= '{default: 1'b0};
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (lane7_cks_vld_i[l]) begin
          cks_ok_q[l] <= lane7_cks_rx_i[l*8 +: 8]
                         == lane7_cks_calc_i[l*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane 0 configuration compare
  assign ilas_rd = ilas_vld_i && (ilas_idx_i < 4'(llsi_pkg::CFG_BYTES));
  llsi_cfg_mem #(
    .AW (MAW),
    .DW (8)
  ) u_cfg_mem (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_en_i    (cfg_wr),
    .wr_addr_i  ({page_q, reg_addr_i[3:0]}),
    .wr_data_i  (reg_wdata_i),
    .rd_en_i    (ilas_rd),
    .rd_addr_i  ({ilas_link_i, ilas_idx_i}),
    .rd_data_o  (mem_rd_data)
  );
  // align the received byte with the registered memory read
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmp_vld_q   <= 1'b0;
      cmp_first_q <= 1'b0;
      cmp_link_q  <= '0;
      cmp_byte_q  <= '0;
    end else begin
      cmp_vld_q   <= ilas_rd;
      cmp_first_q <= ilas_idx_i == 4'h0;
      cmp_link_q  <= ilas_link_i;
      cmp_byte_q  <= ilas_byte_i;
    end
  end
  // sticky mismatch; a new sequence clears it, a miss always wins
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mismatch_q <= '{default: 1'b0};
    end else begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (cmp_vld_q && cmp_link_q == LW'(l)) begin
          if (mem_rd_data != cmp_byte_q) begin
            mismatch_q[l] <= 1'b1;
          end else if (cmp_first_q) begin
            mismatch_q[l] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt combine and routing
  // only enabled sources count; levels pass straight through, so only the mismatch and checksum flags hold an event once it clears
  always_comb begin
    irq_any = 1'b0;
    for (int l = 0; l < NUM_LINKS; l++) begin
      irq_any = irq_any
        | (|(en_a_q[l] & {err_q[l], lane7_ild_i[l], lane7_ils_i[l],
                          cks_ok_q[l], lane7_fs_i[l], lane7_cgs_i[l]}))
        | (en_b_q[l] & mismatch_q[l]);
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_out_first_o  <= 1'b0;
      irq_out_second_o <= 1'b0;
    end else begin
      irq_out_first_o  <= irq_any & ~pin_sel_q;
      irq_out_second_o <= irq_any & pin_sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback
  // status of the paged link
  assign stat_sel = {err_q[page_q], lane7_ild_i[page_q], lane7_ils_i[page_q],
                     cks_ok_q[page_q], lane7_fs_i[page_q], lane7_cgs_i[page_q]};
  // read data follows the address one cycle late; config bytes read zero
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= llsi_pkg::READ_ZERO;
    end else begin
      unique case (reg_addr_i)
        llsi_pkg::LINK_PAGE_ADDR:  reg_rdata_o <= 8'(page_q);
        llsi_pkg::LANE7_STAT_ADDR: reg_rdata_o <= stat_sel;
        llsi_pkg::IRQ_EN_A_ADDR:   reg_rdata_o <= en_a_q[page_q];
        llsi_pkg::IRQ_EN_B_ADDR:   reg_rdata_o <= {7'h00, en_b_q[page_q]};
        llsi_pkg::PIN_SEL_ADDR:    reg_rdata_o <= {7'h00, pin_sel_q};
        llsi_pkg::ERR_THRESH_ADDR: reg_rdata_o <= thresh_q;
        default:                   reg_rdata_o <= llsi_pkg::READ_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_stat_read;
    (reg_addr_i == llsi_pkg::LANE7_STAT_ADDR && !reg_wr_i) |=>
      reg_rdata_o[3:0] == $past({lane7_ils_i[page_q], cks_ok_q[page_q],
                                 lane7_fs_i[page_q], lane7_cgs_i[page_q]});
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("lane 7 status readback wrong");
  property p_cks_cmp;
    lane7_cks_vld_i[0] |=>
      cks_ok_q[0] == ($past(lane7_cks_rx_i[7:0])
                      == $past(lane7_cks_calc_i[7:0]));
  endproperty
  a_cks_cmp: assert property (p_cks_cmp)
    else $error("checksum flag does not follow compare");
  property p_cks_hold;
    !lane7_cks_vld_i[0] |=> $stable(cks_ok_q[0]);
  endproperty
  a_cks_hold: assert property (p_cks_hold)
    else $error("checksum flag moved without link checksum");
  property p_en_write;
    (reg_wr_i && reg_addr_i == llsi_pkg::IRQ_EN_A_ADDR && page_q == '0) |=>
      en_a_q[0] == $past(reg_wdata_i);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write not taken");
  property p_bank_isolate;
    (page_q != '0) |=> $stable(en_a_q[0]) && $stable(en_b_q[0]);
  endproperty
  a_bank_isolate: assert property (p_bank_isolate)
    else $error("write leaked into another link bank");
  property p_err_flag;
    1'b1 |=> err_q[0][2] == ($past(lane7_bde_cnt_i[7:0]) >= $past(thresh_q));
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error flag disagrees with threshold");
  sequence s_cmp_bad;
    cmp_vld_q && cmp_link_q == '0 && mem_rd_data != cmp_byte_q;
  endsequence
  sequence s_ilas_in;
    ilas_vld_i && ilas_link_i == '0 && ilas_idx_i < 4'(llsi_pkg::CFG_BYTES);
  endsequence
  // the flag may only drop after a matching first byte was compared
  property p_mismatch;
    s_ilas_in ##1 s_cmp_bad |=> mismatch_q[0]
      ##1 (mismatch_q[0] || $past(cmp_vld_q && cmp_first_q));
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("configuration mismatch not flagged");
  property p_irq_mask;
    !irq_any |=> !irq_out_first_o && !irq_out_second_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt without enabled source");
  property p_irq_route;
    irq_any |=> (irq_out_first_o != irq_out_second_o)
                && (irq_out_second_o == $past(pin_sel_q));
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("interrupt routed to wrong pin");

endmodule : llsi_top

`default_nettype wire

// ### verification/llsi_tx_model.sv
// transmitter-side model driving lane 7 status and alignment bytes
`timescale 1ns/1ps
`default_nettype none

module llsi_tx_model (
  input  wire logic        clk_i,   // register clock
  output logic [1:0]       ils_o,   // initial lane sync
  output logic [1:0]       fs_o,    // frame sync
  output logic [1:0]       cgs_o,   // code-group sync
  output logic [1:0]       ild_o,   // deskew achieved
  output logic [15:0]      bde_o,   // disparity counts
  output logic [15:0]      nit_o,   // not-in-table counts
  output logic [15:0]      uek_o,   // control char counts
  output logic [1:0]       cvld_o,  // checksum pair valid
  output logic [15:0]      crx_o,   // checksum sent
  output logic [15:0]      ccal_o,  // checksum computed
  output logic             ivld_o,  // alignment byte valid
  output logic             ilink_o, // link of the byte
  output logic [3:0]       iidx_o,  // byte index
  output logic [7:0]       ibyte_o  // alignment byte
);
  // lanes start out of sync with clean counters
  initial begin
    {ils_o, fs_o, cgs_o, ild_o, cvld_o, ivld_o, ilink_o} = '0;
    {bde_o, nit_o, uek_o, crx_o, ccal_o, iidx_o, ibyte_o} = '0;
  end

  // levels of one link, changed just after an edge
  task automatic set_link(input int l, input logic [3:0] lv,
                          input logic [23:0] c);
    @(posedge clk_i) #1;
    {ild_o[l], ils_o[l], fs_o[l], cgs_o[l]} = lv;
    {bde_o[l*8+:8], nit_o[l*8+:8], uek_o[l*8+:8]} = c;
  endtask : set_link

  task automatic send_cks(input int l, input logic [7:0] rx,
                          input logic [7:0] ca);
    @(posedge clk_i) #1;
    crx_o[l*8+:8] = rx;
    ccal_o[l*8+:8] = ca;
    cvld_o[l] = 1'b1;
    @(posedge clk_i) #1;
    cvld_o[l] = 1'b0;
    // released values are both inverted, so a stale sample compares the same as the real pair
    crx_o[l*8+:8] = ~rx;
    ccal_o[l*8+:8] = ~ca;
  endtask : send_cks

  // one lane 0 alignment byte, one cycle long
  task automatic send_byte(input logic l, input logic [3:0] n,
                           input logic [7:0] b);
    @(posedge clk_i) #1;
    {ivld_o, ilink_o, iidx_o, ibyte_o} = {1'b1, l, n, b};
    @(posedge clk_i) #1;
    ivld_o = 1'b0;
    ibyte_o = ~b;
  endtask : send_byte
endmodule : llsi_tx_model
`default_nettype wire

// ### verification/tb_link_lane_status_irq_enable.sv
// self-checking bench for lane 7 status and link interrupt enables
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  fail_count++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end

module tb_link_lane_status_irq_enable;
  logic        clk, rst, wr, ivld, ilink, irq_p1, irq_p2, sel;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, thr, c, v;
  logic [1:0]  ils, fs, cgs, ild, cvld;
  logic [15:0] bde, nit, uek, crx, ccal;
  logic [3:0]  iidx;
  logic [7:0]  ibyte;
  logic [31:0] seed;
  logic [7:0]  en_a [2];
  logic        en_b [2], mm [2], cks_ok [2];
  logic [7:0]  b [14];
  int          fail_count, n_tests, cyc;

  llsi_top #(.NUM_LINKS(2)) uut (.core_clk_i(clk), .sys_rst_i(rst),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .lane7_ils_i(ils), .lane7_fs_i(fs),
    .lane7_cgs_i(cgs), .lane7_ild_i(ild), .lane7_bde_cnt_i(bde),
    .lane7_nit_cnt_i(nit), .lane7_uek_cnt_i(uek),
    .lane7_cks_vld_i(cvld), .lane7_cks_rx_i(crx),
    .lane7_cks_calc_i(ccal), .ilas_vld_i(ivld), .ilas_link_i(ilink),
    .ilas_idx_i(iidx), .ilas_byte_i(ibyte), .irq_out_first_o(irq_p1),
    .irq_out_second_o(irq_p2));

  llsi_tx_model tx (.clk_i(clk), .ils_o(ils), .fs_o(fs), .cgs_o(cgs),
    .ild_o(ild), .bde_o(bde), .nit_o(nit), .uek_o(uek), .cvld_o(cvld),
    .crx_o(crx), .ccal_o(ccal), .ivld_o(ivld), .ilink_o(ilink),
    .iidx_o(iidx), .ibyte_o(ibyte));

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a stuck run is cut here and counted as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // random source and expectations
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // status byte expected from the lane levels the model drives
  function automatic logic [7:0] exp_stat(input int l);
    return {bde[l*8+:8] >= thr, nit[l*8+:8] >= thr, uek[l*8+:8] >= thr,
            ild[l], ils[l], cks_ok[l], fs[l], cgs[l]};
  endfunction : exp_stat

  function automatic logic exp_any();
    logic a;
    a = 1'b0;
    for (int l = 0; l < 2; l++)
      a = a | (|(en_a[l] & exp_stat(l))) | (en_b[l] & mm[l]);
    return a;
  endfunction : exp_any

  ////////////////////////////////////////////////////////////////////
  // register port tasks, one request per task
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {addr, wr, wdata} = {a, 1'b1, d};
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    addr = a;
    @(posedge clk) #1;
    `CHK(rdata, e)
  endtask : chk_reg

  task automatic chk_irq();
    repeat (3) @(posedge clk);
    // pins are registered, so look once the edge has settled them
    #1;
    `CHK({irq_p2, irq_p1}, {sel & exp_any(), !sel & exp_any()})
  endtask : chk_irq

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, wr, addr, wdata, sel, thr} = {1'b1, 22'h0, 8'hff};
    seed = 32'h0000_ed36;
    en_a = '{default: 8'h00};
    {en_b[0], en_b[1], mm[0], mm[1], cks_ok[0], cks_ok[1]} = '0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk_reg(llsi_pkg::IRQ_EN_A_ADDR, 8'h00);
    chk_reg(llsi_pkg::LANE7_STAT_ADDR, 8'h00);
    wr_reg(llsi_pkg::CFG_LAST_ADDR, 8'h5a);
    // random lanes, enables and routing; first passes have no enables
    for (int i = 0; i < 24; i++) begin
      thr = rnd();
      v = rnd();
      sel = v[7];
      wr_reg(llsi_pkg::ERR_THRESH_ADDR, thr);
      wr_reg(llsi_pkg::PIN_SEL_ADDR, {7'h0, sel});
      for (int l = 0; l < 2; l++) begin
        v = rnd();
        en_a[l] = (i < 2) ? 8'h00 : rnd();
        tx.set_link(l, (i < 2) ? 4'hf : v[3:0],
                    {rnd(), rnd(), (i == 3) ? thr : rnd()});
        wr_reg(llsi_pkg::LINK_PAGE_ADDR, 8'(l));
        wr_reg(llsi_pkg::IRQ_EN_A_ADDR, en_a[l]);
        c = rnd();
        tx.send_cks(l, c, v[4] ? c : ~c);
        cks_ok[l] = v[4];
      end
      chk_irq();
      for (int l = 0; l < 2; l++) begin
        wr_reg(llsi_pkg::LINK_PAGE_ADDR, 8'(l));
        chk_reg(llsi_pkg::IRQ_EN_A_ADDR, en_a[l]);
        chk_reg(llsi_pkg::LANE7_STAT_ADDR, exp_stat(l));
        chk_reg(llsi_pkg::LINK_PAGE_ADDR, 8'(l));
      end
      chk_reg(llsi_pkg::ERR_THRESH_ADDR, thr);
      chk_reg(llsi_pkg::PIN_SEL_ADDR, {7'h0, sel});
    end
    // lane 0 alignment compare on link 0 only
    for (int l = 1; l >= 0; l--) begin
      wr_reg(llsi_pkg::LINK_PAGE_ADDR, 8'(l));
      wr_reg(llsi_pkg::IRQ_EN_A_ADDR, 8'h00);
      en_a[l] = 8'h00;
    end
    for (int n = 0; n < 14; n++) begin
      b[n] = rnd();
      wr_reg(llsi_pkg::CFG_FIRST_ADDR + 12'(n), b[n]);
    end
    chk_reg(llsi_pkg::CFG_FIRST_ADDR, 8'h00);
    chk_reg(12'h0123, 8'h00);
    wr_reg(llsi_pkg::IRQ_EN_B_ADDR, 8'hff);
    chk_reg(llsi_pkg::IRQ_EN_B_ADDR, 8'h01);
    en_b[0] = 1'b1;
    for (int n = 0; n < 14; n++)
      tx.send_byte(1'b0, 4'(n), b[n]);
    tx.send_byte(1'b0, 4'd14, ~b[0]);
    chk_irq();
    tx.send_byte(1'b0, 4'd13, ~b[13]);
    mm[0] = 1'b1;
    chk_irq();
    wr_reg(llsi_pkg::IRQ_EN_B_ADDR, 8'h00);
    en_b[0] = 1'b0;
    chk_irq();
    end_sim();
  end
endmodule : tb_link_lane_status_irq_enable
`default_nettype wire
